// ---- rtl/pargen_pkg.sv ----
// Functional notes
// - Indirect RAM address joins page, column, row
// - Direct access: second word is address
// - Scratch window spans 040h to 04Fh
// - Long jumps load all 14 counter bits
// - In-page jump replaces low eight bits
// - Page-boundary jump lands on next page
// - Zero-page call loads six bits, clears rest
// - Table jump target from immediate, accumulator pair
// - Flag bit 8 writes accumulator pair
// - Flag bit 9 writes port latches
// - Table read leaves counter advancing normally
// - Program words are ten bits wide
package pargen_pkg;
  localparam int PC_W        = 14;
  localparam int RAM_AW      = 10;
  localparam int ROM_W       = 10;
  localparam int PAGE_BITS   = 6;
  localparam int OFFS_BITS   = 8;
  localparam int ZP_BITS     = 6;
  localparam int TBL_IMM_W   = 4;
  localparam int FLAG_ACC    = 8;
  localparam int FLAG_PORT   = 9;
  localparam logic [RAM_AW-1:0] SCRATCH_BASE = 10'h040;
  localparam logic [PC_W-1:0]   PC_RESET     = 14'h0000;
  localparam logic [OFFS_BITS-1:0] PAGE_LAST = 8'hFF;

  // Operation requested by the instruction decoder
  typedef enum logic [3:0] {
    PARGEN_NOP      = 4'h0,
    PARGEN_SEQ      = 4'h1,
    PARGEN_LJMP     = 4'h2,
    PARGEN_LBR      = 4'h3,
    PARGEN_LCALL    = 4'h4,
    PARGEN_PGJMP    = 4'h5,
    PARGEN_ZPCALL   = 4'h6,
    PARGEN_TBLJMP   = 4'h7,
    PARGEN_TBLREAD  = 4'h8,
    PARGEN_RAMIND   = 4'h9,
    PARGEN_RAMDIR   = 4'hA,
    PARGEN_SCRATCH  = 4'hB
  } pargen_op_t;
endpackage

// ---- rtl/pargen_ram_if.sv ----
`timescale 1ns/100ps
// RAM address request from the core to the RAM address former
interface pargen_ram_if;
  import pargen_pkg::*;
  logic [1:0]        mode;
  logic [3:0]        page_sel;
  logic [3:0]        col_sel;
  logic [1:0]        row_sel;
  logic [RAM_AW-1:0] dir_word;
  logic [3:0]        scr_idx;
  logic [RAM_AW-1:0] addr;
  modport core (output mode, page_sel, col_sel, row_sel, dir_word, scr_idx,
                input addr);
  modport gen  (input mode, page_sel, col_sel, row_sel, dir_word, scr_idx,
                output addr);
endinterface

// ---- rtl/pargen_ram_addr.sv ----
`timescale 1ns/100ps
// Combinational RAM address former for the three RAM modes
module pargen_ram_addr (
  pargen_ram_if.gen ram
);
  import pargen_pkg::*;

  wire [RAM_AW-1:0] ind_addr;
  wire [RAM_AW-1:0] scr_addr;

  // Indirect: page, column and row selects joined into ten bits
  assign ind_addr = {ram.page_sel, ram.col_sel, ram.row_sel};
  // Scratch window: sixteen words from the window base
  assign scr_addr = SCRATCH_BASE | {6'h00, ram.scr_idx};
  // Mode select: 0 indirect, 1 direct second word, 2 scratch
  assign ram.addr = (ram.mode == 2'h1) ? ram.dir_word :
                    (ram.mode == 2'h2) ? scr_addr : ind_addr;
endmodule

// ---- rtl/pargen_top.sv ----
`timescale 1ns/100ps
// Program counter and RAM address generation with table read routing
module pargen_top #(
  parameter int TBL_IMM_WIDTH = 4
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic                           op_valid,
  input  wire pargen_pkg::pargen_op_t         op,
  input  wire logic [pargen_pkg::PC_W-1:0]    imm,
  input  wire logic [3:0]                     acc_in,
  input  wire logic [3:0]                     second_acc_in,
  input  wire logic [3:0]                     ram_page_sel,
  input  wire logic [3:0]                     ram_col_sel,
  input  wire logic [1:0]                     ram_row_sel,
  input  wire logic [pargen_pkg::RAM_AW-1:0]  ram_dir_word,
  input  wire logic [3:0]                     scratch_idx,
  input  wire logic [pargen_pkg::ROM_W-1:0]   table_word,
  output logic      [pargen_pkg::PC_W-1:0]    instr_counter,
  output logic      [pargen_pkg::PC_W-1:0]    table_addr,
  output logic      [pargen_pkg::RAM_AW-1:0]  ram_addr,
  output logic      [3:0]                     accumulator,
  output logic      [3:0]                     second_acc_reg,
  output logic      [3:0]                     port_one_latch,
  output logic      [3:0]                     port_two_latch,
  output logic                                acc_load,
  output logic                                port_load
);
  import pargen_pkg::*;

  initial begin
    if (TBL_IMM_WIDTH != TBL_IMM_W)
      $error("pargen_top: table immediate must be four bits");
  end

  pargen_ram_if ram_i ();

  wire              is_op;
  wire [PC_W-1:0]   pc_inc;
  wire [PAGE_BITS-1:0] dest_page;
  wire [PC_W-1:0]   pg_target;
  wire [PC_W-1:0]   zp_target;
  wire [PC_W-1:0]   tbl_target;
  wire              tbl_acc_hit;
  wire              tbl_port_hit;
  wire [1:0]        ram_mode;
  logic [PC_W-1:0]  next_instr_counter;

  assign is_op = op_valid;

  // Sequential fetch address
  assign pc_inc = instr_counter + 14'h0001;

  // Page of an in-page jump; a jump in the last word goes to the next page
  assign dest_page = (instr_counter[OFFS_BITS-1:0] == PAGE_LAST) ?
                     instr_counter[PC_W-1:OFFS_BITS] + 6'h01 :
                     instr_counter[PC_W-1:OFFS_BITS];
  assign pg_target = {dest_page, imm[OFFS_BITS-1:0]};

  // Zero-page call: six low bits loaded, eight high bits cleared
  assign zp_target = {8'h00, imm[ZP_BITS-1:0]};

  // Table address from four-bit immediate and the accumulator pair
  assign tbl_target = {2'h0, imm[TBL_IMM_W-1:0], second_acc_in,
                       acc_in};
  assign table_addr = tbl_target;

  // Flag bits of the fetched ten-bit table word steer the data
  assign tbl_acc_hit  = table_word[FLAG_ACC];
  assign tbl_port_hit = table_word[FLAG_PORT];

  // Next counter value per operation
  always_comb begin
    next_instr_counter = instr_counter;
    if (is_op) begin
      unique case (op)
        PARGEN_LJMP, PARGEN_LBR, PARGEN_LCALL:
          next_instr_counter = imm;
        PARGEN_PGJMP:   next_instr_counter = pg_target;
        PARGEN_ZPCALL:  next_instr_counter = zp_target;
        PARGEN_TBLJMP:  next_instr_counter = tbl_target;
        PARGEN_TBLREAD: next_instr_counter = pc_inc;
        PARGEN_NOP:     next_instr_counter = instr_counter;
        default:        next_instr_counter = pc_inc;
      endcase
    end
  end

  // Program counter register
  always_ff @(posedge sys_clk) begin
    if (rst)
      instr_counter <= PC_RESET;
    else
      instr_counter <= next_instr_counter;
  end

  // Table read routing into accumulator pair and port latches
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accumulator    <= 4'h0;
      second_acc_reg <= 4'h0;
      port_one_latch <= 4'h0;
      port_two_latch <= 4'h0;
      acc_load       <= 1'b0;
      port_load      <= 1'b0;
    end else begin
      acc_load  <= is_op && op == PARGEN_TBLREAD && tbl_acc_hit;
      port_load <= is_op && op == PARGEN_TBLREAD && tbl_port_hit;
      if (is_op && op == PARGEN_TBLREAD && tbl_acc_hit) begin
        accumulator    <= table_word[3:0];
        second_acc_reg <= table_word[7:4];
      end
      if (is_op && op == PARGEN_TBLREAD && tbl_port_hit) begin
        port_one_latch <= table_word[3:0];
        port_two_latch <= table_word[7:4];
      end
    end
  end

  // RAM addressing mode chosen by operation
  assign ram_mode = (op == PARGEN_RAMDIR)  ? 2'h1 :
                    (op == PARGEN_SCRATCH) ? 2'h2 : 2'h0;

  assign ram_i.mode     = ram_mode;
  assign ram_i.page_sel = ram_page_sel;
  assign ram_i.col_sel  = ram_col_sel;
  assign ram_i.row_sel  = ram_row_sel;
  assign ram_i.dir_word = ram_dir_word;
  assign ram_i.scr_idx  = scratch_idx;

  pargen_ram_addr u_ram (
    .ram (ram_i.gen)
  );

  // Registered RAM address
  always_ff @(posedge sys_clk) begin
    if (rst)
      ram_addr <= 10'h000;
    else if (is_op)
      ram_addr <= ram_i.addr;
  end
endmodule

// ---- sim/pargen_monitor.sv ----
`timescale 1ns/100ps
// Checks each taken op except no-op, sequential step and table jump against its result one cycle later
module pargen_monitor
  import pargen_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              op_valid,
  input wire pargen_op_t        op,
  input wire logic [PC_W-1:0]   imm,
  input wire logic [3:0]        ram_page_sel,
  input wire logic [3:0]        ram_col_sel,
  input wire logic [1:0]        ram_row_sel,
  input wire logic [RAM_AW-1:0] ram_dir_word,
  input wire logic [3:0]        scratch_idx,
  input wire logic [ROM_W-1:0]  table_word,
  input wire logic [PC_W-1:0]   instr_counter,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [3:0]        accumulator,
  input wire logic [3:0]        port_one_latch,
  input wire logic              acc_load,
  input wire logic              port_load
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Taken table read decode for the table read checks below
  wire go_read = op_valid && op == PARGEN_TBLREAD;
  property p_ind;
    op_valid && op == PARGEN_RAMIND |=> ram_addr ==
      $past({ram_page_sel, ram_col_sel, ram_row_sel});
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address");
  property p_dir;
    op_valid && op == PARGEN_RAMDIR |=> ram_addr == $past(ram_dir_word);
  endproperty
  a_dir: assert property (p_dir) else $error("direct address");
  property p_scr;
    op_valid && op == PARGEN_SCRATCH |=> ram_addr[9:4] == 6'h04 &&
      ram_addr[3:0] == $past(scratch_idx);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch address");
  property p_long;
    op_valid && op inside {PARGEN_LJMP, PARGEN_LBR, PARGEN_LCALL}
      |=> instr_counter == $past(imm);
  endproperty
  a_long: assert property (p_long) else $error("long jump");
  property p_pg;
    op_valid && op == PARGEN_PGJMP |=> instr_counter ==
      {$past(instr_counter[13:8]) + ($past(instr_counter[7:0]) == 8'hFF),
       $past(imm[7:0])};
  endproperty
  a_pg: assert property (p_pg) else $error("page jump");
  property p_zp;
    op_valid && op == PARGEN_ZPCALL |=> instr_counter == {8'h00, $past(imm[5:0])};
  endproperty
  a_zp: assert property (p_zp) else $error("zero page call");
  property p_acc;
    go_read && table_word[8] |=> acc_load &&
      accumulator == $past(table_word[3:0]);
  endproperty
  a_acc: assert property (p_acc) else $error("acc load");
  property p_port;
    go_read |=> port_load == $past(table_word[9]) &&
      (!port_load || port_one_latch == $past(table_word[3:0]));
  endproperty
  a_port: assert property (p_port) else $error("port load");
  property p_tpc;
    go_read |=> instr_counter == $past(instr_counter) + 14'h0001;
  endproperty
  a_tpc: assert property (p_tpc) else $error("table read counter");
endmodule
bind pargen_top pargen_monitor mon_u (.*);

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import pargen_pkg::*;
  logic sys_clk = 0, rst = 1, op_valid = 0;
  pargen_op_t op = PARGEN_NOP;
  logic [13:0] imm = 0, ic, ta;
  logic [3:0] acc_in = 0, sacc_in = 0, pg = 0, col = 0, idx = 0;
  logic [3:0] acc, sacc, p1, p2;
  logic [1:0] row = 0;
  logic [9:0] dw = 0, tw = 0, ra;
  logic acc_load, port_load;
  int n_errors = 0, total_checks = 0;
  pargen_top dut_u (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid),
    .op(op), .imm(imm), .acc_in(acc_in), .second_acc_in(sacc_in),
    .ram_page_sel(pg), .ram_col_sel(col), .ram_row_sel(row),
    .ram_dir_word(dw), .scratch_idx(idx), .table_word(tw),
    .instr_counter(ic), .table_addr(ta), .ram_addr(ra), .accumulator(acc),
    .second_acc_reg(sacc), .port_one_latch(p1), .port_two_latch(p2),
    .acc_load(acc_load), .port_load(port_load));
  // Clock source
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // One taken op, results settled on return
  task automatic run(input pargen_op_t o, input logic [13:0] i);
    @(negedge sys_clk);
    op = o;
    imm = i;
    op_valid = 1;
    @(negedge sys_clk);
    op_valid = 0;
  endtask
  task t_ram;
    {pg, col, row, dw, idx} = {4'hA, 4'h5, 2'h3, 10'h3C1, 4'hF};
    run(PARGEN_RAMIND, 14'h0000);
    `CHK(ra, 10'h297)
    run(PARGEN_RAMDIR, 14'h0000);
    `CHK(ra, 10'h3C1)
    run(PARGEN_SCRATCH, 14'h0000);
    `CHK(ra, 10'h04F)
  endtask
  task t_jump;
    run(PARGEN_LJMP, 14'h3FFF);
    `CHK(ic, 14'h3FFF)
    run(PARGEN_LBR, 14'h01FF);
    `CHK(ic, 14'h01FF)
    run(PARGEN_PGJMP, 14'h0012);
    `CHK(ic, 14'h0212)
    run(PARGEN_PGJMP, 14'h00FF);
    `CHK(ic, 14'h02FF)
    run(PARGEN_LCALL, 14'h3FFF);
    run(PARGEN_PGJMP, 14'h0007);
    `CHK(ic, 14'h0007)
    run(PARGEN_ZPCALL, 14'h3FEA);
    `CHK(ic, 14'h002A)
    {acc_in, sacc_in} = {4'h3, 4'hC};
    run(PARGEN_TBLJMP, 14'h0009);
    `CHK(ic, 14'h09C3)
    `CHK(ta, 14'h09C3)
  endtask
  // Flag bits pick the destinations of each table word
  task t_read;
    logic [9:0] w [4] = '{10'h3AB, 10'h0CD, 10'h1EF, 10'h254};
    logic [15:0] e [4] = '{16'hBABA, 16'hBABA, 16'hFEBA, 16'hFE45};
    run(PARGEN_LJMP, 14'h0100);
    for (int k = 0; k < 4; k++) begin
      tw = w[k];
      run(PARGEN_TBLREAD, 14'h0000);
      `CHK({acc, sacc, p1, p2}, e[k])
      `CHK({acc_load, port_load}, {w[k][8], w[k][9]})
      `CHK(ic, 14'h0101 + 14'(k))
    end
  endtask
  task finish_test;
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 0;
    `CHK({ic, ra}, 24'h000000)
    t_ram();
    t_jump();
    t_read();
    finish_test();
  end
endmodule
